// file: common/psdm_pkg.sv
// Purpose: shared constants and types for the pump sleep / dry-run monitor
// Assumes: 250 MHz clock, measurements already scaled to plain unsigned words
// Notes: power factor is fixed point with 8 fraction bits (0x0100 = 1.0)
package psdm_pkg;
    localparam int CLK_HZ = 250_000_000;                    // control clock rate
    localparam int TICK_MS = 1;                             // timer tick period in ms
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;   // cycles per timer tick
    localparam int FW = 16;                                 // frequency word width
    localparam int PW = 20;                                 // power word width (W)
    localparam int XW = 16;                                 // pressure word width
    localparam int TW = 24;                                 // timer count width in ticks
    localparam int FACT_FRAC = 8;                           // fraction bits of curve factor
    localparam logic [15:0] SLEEP_TIMER_MAX_S = 16'h270F;   // 9999 s upper setting
    localparam logic [7:0] DRY_TIMEOUT_MIN_S = 8'h05;       // 5 s lowest dry-run timeout
    localparam logic [7:0] DRY_TIMEOUT_OFF_S = 8'h1E;       // 30 s setting disables detection
    localparam logic [7:0] INTERLOCK_MIN_HALFMIN = 8'h01;   // 0.5 min lowest interlock
    localparam logic [7:0] INTERLOCK_MAX_HALFMIN = 8'h78;   // 60 min highest interlock
    localparam logic [15:0] TICKS_PER_S = 16'h03E8;         // 1000 ticks per second
    localparam logic [15:0] TICKS_PER_HALFMIN = 16'h7530;   // 30000 ticks per half minute

    // measurements from the power stage
    typedef struct packed {
        logic [FW-1:0] freq;       // output frequency
        logic [PW-1:0] power;      // measured motor power
        logic [XW-1:0] feedback;   // pressure feedback
        logic [XW-1:0] reference;  // active reference
    } psdm_meas_t;

    // settings from the parameter store
    typedef struct packed {
        logic closed_loop;                       // 1 closed loop, 0 open loop
        logic below_curve_sleeps;                // 1 sleep action, 0 trip action on low power in closed loop; open loop always trips
        logic boost_en;                          // raise pressure before sleep stop
        logic auto_reset;                        // automatic restart after dry-run trip
        logic [15:0] sleep_s;                    // sleep qualifying timer in s, 0 off
        logic [7:0] dry_s;                       // dry-run timeout in s, 30 off
        logic [7:0] interlock_hm;                // interlock time in half minutes
        logic [15:0] restart_s;                  // automatic restart interval in s
        logic [FW-1:0] freq_min_pt;              // curve lower frequency point
        logic [FW-1:0] freq_max_pt;              // curve upper frequency point
        logic [PW-1:0] pow_min_pt;               // power at lower point
        logic [PW-1:0] pow_max_pt;               // power at upper point
        logic [9:0] curve_power_factor;          // curve multiplier, 8 fraction bits
        logic [FW-1:0] output_freq_upper_limit;  // maximum output frequency
        logic [FW-1:0] output_freq_lower_limit;  // minimum output frequency
        logic [XW-1:0] reference_lower_limit;    // minimum reference
        logic [XW-1:0] wakeup_pressure;          // wakeup threshold
        logic [XW-1:0] boost_setpoint;           // boost pressure target
        logic [15:0] boost_timeout_s;            // boost time limit in s, 0 off
    } psdm_cfg_t;

    typedef enum {
        ST_RUN,
        ST_BOOST,
        ST_SLEEP,
        ST_TRIP
    } psdm_state_t;
endpackage : psdm_pkg

// file: rtl/psdm_curve.sv
// Purpose: no/low-flow power curve, interpolated and scaled
// Assumes: freq_max_pt above freq_min_pt; frequency clamped to the points
// Notes: one register stage; result valid one cycle after inputs
module psdm_curve
    import psdm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // inputs
    input wire logic [FW-1:0] freq,
    input wire psdm_cfg_t cfg,
    // output
    output logic [PW-1:0] curve_power
);
    logic [PW-1:0] curve_reg;  // registered curve value
    logic [PW-1:0] curve_next; // next curve value

    // linear interpolation between the two points, then the factor
    always_comb begin
        logic [FW-1:0] f;
        logic [FW-1:0] span;
        logic signed [PW+1:0] dp;
        logic signed [PW+FW+2:0] prod;
        logic signed [PW+1:0] base;
        logic [PW+9:0] scaled;
        f = freq;
        span = cfg.freq_max_pt - cfg.freq_min_pt;
        dp = $signed({2'b00, cfg.pow_max_pt}) - $signed({2'b00, cfg.pow_min_pt});
        prod = '0;
        base = $signed({2'b00, cfg.pow_min_pt});
        scaled = '0;
        // clamp the frequency into the point range
        if (f < cfg.freq_min_pt) begin
            f = cfg.freq_min_pt;
        end else if (f > cfg.freq_max_pt) begin
            f = cfg.freq_max_pt;
        end
        // interpolate every frequency in between
        if (span != '0) begin
            prod = dp * $signed({3'b000, f - cfg.freq_min_pt});
            base = base + (PW+2)'(prod / $signed({3'b000, span}));
        end
        // whole curve multiplied by the factor
        scaled = (PW+10)'(base[PW-1:0]) * (PW+10)'(cfg.curve_power_factor);
        scaled = scaled >> FACT_FRAC;
        curve_next = (scaled[PW+9:PW] != '0) ? {PW{1'b1}} : scaled[PW-1:0];
    end

    // register the curve value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            curve_reg <= '0;
        end else begin
            curve_reg <= curve_next;
        end
    end

    assign curve_power = curve_reg;
endmodule : psdm_curve

// file: rtl/psdm_monitor.sv
// Purpose: enhanced sleep and dry-run supervision of a pump drive
// Assumes: measurement and setting inputs are synchronous to clk
// Notes: timers count 1 ms ticks; manual reset is a one-cycle pulse

// How it works
// - sleep evaluated only in closed loop
// - power below curve for timer requests sleep
// - feedback over reference at minimum speed sleeps
// - in sleep, low pressure restarts motor
// - sleep timer 0..9999 s, zero disables
// - leaving run for boost or sleep only at timer expiry; waking at timer expiry or when sleep is disabled
// - dry-run detector in both loop modes
// - closed loop: max freq, low feedback, low power
// - open loop: low power alone trips
// - manual or automatic restart after trip
// - sleep and dry-run enabled independently
// - curve interpolated between two points
// - low power selects sleep or trip action in closed loop; in open loop it always trips
// - optional pressure boost before sleep stop
// - dry timeout 5..30 s, 30 disables
// - curve power multiplied by factor
// - reset rejected until interlock timer expires
// - wakeup needs low pressure for timer period
module psdm_monitor
    import psdm_pkg::*;
#(parameter int TICK_DIV = TICK_CYCLES)  // cycles per timer tick; default is the 1 ms tick
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // measurements and settings
    input wire psdm_meas_t meas,
    input wire psdm_cfg_t cfg,
    input wire logic manual_reset,
    // drive commands and status
    output logic motor_run,
    output logic sleep_active,
    output logic boost_active,
    output logic dry_run_trip,
    output logic reset_allowed,
    output logic [PW-1:0] curve_power
);
    logic rst_s1_reg;      // reset release stage 1
    logic rst_s2_reg;      // synchronised reset
    logic rst_ok;          // design-wide reset
    logic [17:0] tick_cnt_reg;
    logic [17:0] tick_cnt_next;
    logic tick;            // one pulse per ms
    psdm_state_t state_reg;
    psdm_state_t state_next;
    logic [TW-1:0] qual_reg;   // sleep / wake qualifying count
    logic [TW-1:0] qual_next;
    logic [TW-1:0] dry_reg;    // dry-run qualifying count
    logic [TW-1:0] dry_next;
    logic [TW-1:0] aux_reg;    // boost, interlock and restart count
    logic [TW-1:0] aux_next;
    logic ilk_done_reg;        // interlock time passed
    logic ilk_done_next;
    logic [TW-1:0] sleep_lim;
    logic [TW-1:0] dry_lim;
    logic [TW-1:0] ilk_lim;
    logic [TW-1:0] boost_lim;
    logic [TW-1:0] restart_lim;
    logic below;               // power under curve
    logic sleep_en;
    logic dry_en;
    logic sleep_cond;
    logic dry_cond;
    logic wake_cond;

    // seconds to ticks, saturating at the count width
    function automatic logic [TW-1:0] to_ticks(input logic [15:0] n, input logic [15:0] per);
        logic [31:0] p;
        p = 32'(n) * 32'(per);
        to_ticks = (p[31:TW] != '0) ? {TW{1'b1}} : p[TW-1:0];
    endfunction : to_ticks

    // reset release through two flip-flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign rst_ok = rst_s2_reg;

    // power curve
    psdm_curve u_curve (
        .clk(clk),
        .rst_n(rst_ok),
        .freq(meas.freq),
        .cfg(cfg),
        .curve_power(curve_power)
    );

    // timer limits and conditions
    always_comb begin
        logic [7:0] ilk;
        logic [7:0] dry;
        ilk = cfg.interlock_hm;
        dry = cfg.dry_s;
        if (ilk < INTERLOCK_MIN_HALFMIN) begin
            ilk = INTERLOCK_MIN_HALFMIN;
        end else if (ilk > INTERLOCK_MAX_HALFMIN) begin
            ilk = INTERLOCK_MAX_HALFMIN;
        end
        if (dry < DRY_TIMEOUT_MIN_S) begin
            dry = DRY_TIMEOUT_MIN_S;
        end
        sleep_lim = to_ticks((cfg.sleep_s > SLEEP_TIMER_MAX_S) ? SLEEP_TIMER_MAX_S : cfg.sleep_s,
                             TICKS_PER_S);
        dry_lim = to_ticks({8'h00, dry}, TICKS_PER_S);
        ilk_lim = to_ticks({8'h00, ilk}, TICKS_PER_HALFMIN);
        boost_lim = to_ticks(cfg.boost_timeout_s, TICKS_PER_S);
        restart_lim = to_ticks(cfg.restart_s, TICKS_PER_S);
        below = meas.power < curve_power;
        sleep_en = cfg.closed_loop && (cfg.sleep_s != 16'h0000);
        dry_en = dry >= DRY_TIMEOUT_MIN_S && cfg.dry_s < DRY_TIMEOUT_OFF_S;
        // low power goes to sleep only when that action is selected
        sleep_cond = sleep_en && ((below && cfg.below_curve_sleeps)
            || (meas.feedback > meas.reference && meas.freq <= cfg.output_freq_lower_limit));
        if (cfg.closed_loop) begin
            dry_cond = dry_en && below && !cfg.below_curve_sleeps
                && meas.freq >= cfg.output_freq_upper_limit
                && meas.feedback < cfg.reference_lower_limit;
        end else begin
            dry_cond = dry_en && below;
        end
        wake_cond = meas.feedback < cfg.wakeup_pressure;
    end

    // tick divider
    always_comb begin
        tick = tick_cnt_reg == 18'(TICK_DIV - 1);
        tick_cnt_next = tick ? '0 : tick_cnt_reg + 18'h0_0001;
    end

    // state machine and timers
    always_comb begin
        state_next = state_reg;
        qual_next = qual_reg;
        dry_next = dry_reg;
        aux_next = aux_reg;
        ilk_done_next = ilk_done_reg;
        // dry-run timer runs while running or boosting
        if (dry_cond && (state_reg == ST_RUN || state_reg == ST_BOOST)) begin
            if (tick) begin
                dry_next = dry_reg + 1'b1;
            end
        end else begin
            dry_next = '0;
        end
        case (state_reg)
            ST_RUN: begin
                if (sleep_cond) begin
                    if (tick) begin
                        qual_next = qual_reg + 1'b1;
                    end
                end else begin
                    qual_next = '0;
                end
                if (dry_cond && dry_reg >= dry_lim) begin
                    state_next = ST_TRIP;
                    aux_next = '0;
                    ilk_done_next = 1'b0;
                end else if (sleep_cond && qual_reg >= sleep_lim) begin
                    qual_next = '0;
                    aux_next = '0;
                    state_next = cfg.boost_en ? ST_BOOST : ST_SLEEP;
                end
            end
            ST_BOOST: begin
                if (tick) begin
                    aux_next = aux_reg + 1'b1;
                end
                if (dry_cond && dry_reg >= dry_lim) begin
                    state_next = ST_TRIP;
                    aux_next = '0;
                    ilk_done_next = 1'b0;
                end else if (meas.feedback >= cfg.boost_setpoint) begin
                    state_next = ST_SLEEP;
                end else if (cfg.boost_timeout_s != 16'h0000 && aux_reg >= boost_lim) begin
                    state_next = ST_RUN;
                end
            end
            ST_SLEEP: begin
                if (wake_cond) begin
                    if (tick) begin
                        qual_next = qual_reg + 1'b1;
                    end
                end else begin
                    qual_next = '0;
                end
                if (wake_cond && qual_reg >= sleep_lim) begin
                    qual_next = '0;
                    state_next = ST_RUN;
                end else if (!sleep_en) begin
                    qual_next = '0;
                    state_next = ST_RUN;
                end
            end
            ST_TRIP: begin
                if (tick) begin
                    aux_next = aux_reg + 1'b1;
                end
                if (!ilk_done_reg && aux_reg >= ilk_lim) begin
                    ilk_done_next = 1'b1;
                    aux_next = '0;
                end
                // reset taken only after the interlock time
                if (ilk_done_reg && (manual_reset
                    || (cfg.auto_reset && aux_reg >= restart_lim))) begin
                    state_next = ST_RUN;
                    aux_next = '0;
                    qual_next = '0;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    // register all state
    always_ff @(posedge clk or negedge rst_ok) begin
        if (!rst_ok) begin
            tick_cnt_reg <= '0;
            state_reg <= ST_RUN;
            qual_reg <= '0;
            dry_reg <= '0;
            aux_reg <= '0;
            ilk_done_reg <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            state_reg <= state_next;
            qual_reg <= qual_next;
            dry_reg <= dry_next;
            aux_reg <= aux_next;
            ilk_done_reg <= ilk_done_next;
        end
    end

    // outputs decoded from the state
    assign motor_run = state_reg == ST_RUN || state_reg == ST_BOOST;
    assign sleep_active = state_reg == ST_SLEEP;
    assign boost_active = state_reg == ST_BOOST;
    assign dry_run_trip = state_reg == ST_TRIP;
    assign reset_allowed = dry_run_trip && ilk_done_reg;

    // trip never leaves before the interlock ends
    chk_trip_interlock: assert property (@(posedge clk) disable iff (!rst_ok)
        (state_reg == ST_TRIP && !ilk_done_reg) |=> state_reg == ST_TRIP)
        else $error("dry-run trip released before interlock");
    // sleep entry only in closed loop with timer set
    chk_sleep_closed: assert property (@(posedge clk) disable iff (!rst_ok)
        (state_reg == ST_RUN && state_next == ST_SLEEP) |-> (cfg.closed_loop && cfg.sleep_s != 16'h0000))
        else $error("sleep entered outside closed loop");
    // sleep entry only at timer expiry
    chk_sleep_expiry: assert property (@(posedge clk) disable iff (!rst_ok)
        (state_reg == ST_RUN && state_next != ST_RUN && state_next != ST_TRIP) |-> qual_reg >= sleep_lim)
        else $error("sleep entered before timer expiry");
    // wake only after low pressure qualified
    chk_wake_qual: assert property (@(posedge clk) disable iff (!rst_ok)
        (state_reg == ST_SLEEP && state_next == ST_RUN && sleep_en) |-> (wake_cond && qual_reg >= sleep_lim))
        else $error("wake without qualified low pressure");
    // trip only after dry timeout
    chk_trip_timeout: assert property (@(posedge clk) disable iff (!rst_ok)
        (state_reg != ST_TRIP && state_next == ST_TRIP) |-> (dry_en && dry_reg >= dry_lim))
        else $error("trip before dry-run timeout");
    // closed loop trip needs max frequency and low feedback
    chk_trip_closed: assert property (@(posedge clk) disable iff (!rst_ok)
        (!dry_run_trip && state_next == ST_TRIP && cfg.closed_loop)
        |-> (meas.freq >= cfg.output_freq_upper_limit && meas.feedback < cfg.reference_lower_limit))
        else $error("closed loop trip without conditions");
    // dry timer clears when condition drops
    chk_dry_clear: assert property (@(posedge clk) disable iff (!rst_ok)
        !dry_cond |=> dry_reg == '0)
        else $error("dry timer kept count");
    // trip entry follows below-curve power
    chk_trip_power: assert property (@(posedge clk) disable iff (!rst_ok)
        $rose(dry_run_trip) |-> $past(below))
        else $error("trip without low power");
endmodule : psdm_monitor

// file: tb/psdm_pump_model.sv
// Purpose: behavioural stand-in for the power stage and pressure transmitter
// Assumes: the bench sets the operating point it wants the pump to show
// Notes: a stopped motor shows zero frequency and zero power, as a real stage does
module psdm_pump_model
    import psdm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // drive command and wanted operating point
    input wire logic motor_run,
    input wire psdm_meas_t target,
    // measurements towards the monitor
    output psdm_meas_t meas
);
    timeunit 1ns;
    timeprecision 100ps;

    // measurements settle one clock after the operating point moves
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meas <= '0;
        end else begin
            // a stopped motor neither turns nor draws power
            meas.freq <= motor_run ? target.freq : '0;
            meas.power <= motor_run ? target.power : '0;
            // pressure and reference are there whether or not it runs
            meas.feedback <= target.feedback;
            meas.reference <= target.reference;
        end
    end
endmodule : psdm_pump_model

// file: tb/test_psdm_monitor.sv
// Purpose: self-checking bench for the pump sleep / dry-run monitor
// Assumes: timer tick shortened to one clock, so 1 s of setting lasts 1000 cycles
// Notes: checks reset state, the power curve, sleep, wake, boost, dry-run trip, interlock and restarts
module test_psdm_monitor
    import psdm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int LIMIT = 96000; // cycle ceiling, tests need about 90000
    logic clk; // control clock
    logic rst_n; // active-low reset
    logic manual_reset; // operator reset pulse
    psdm_cfg_t cfg; // settings
    psdm_meas_t target; // wanted pump operating point
    psdm_meas_t meas; // measurements from the model
    logic motor_run; // drive outputs
    logic sleep_active;
    logic boost_active;
    logic dry_run_trip;
    logic reset_allowed;
    logic [PW-1:0] curve_power;
    int n_fail = 0; // mismatches
    int n_checks = 0; // comparisons made
    int cycles = 0; // timeout counter
    // curve table: frequency, factor, expected curve power
    logic [FW-1:0] c_freq [8] = '{16'h0014, 16'h001E, 16'h0032, 16'h000A, 16'h003C, 16'h001E, 16'h001E, 16'h0028};
    logic [9:0] c_fact [8] = '{10'h100, 10'h100, 10'h100, 10'h100, 10'h100, 10'h180, 10'h080, 10'h100};
    logic [PW-1:0] c_exp [8] = '{20'h0_03E8, 20'h0_07D0, 20'h0_0FA0, 20'h0_03E8, 20'h0_0FA0, 20'h0_0BB8,
        20'h0_03E8, 20'h0_0BB8};

    psdm_monitor #(.TICK_DIV(1)) psdm_monitor_i (.clk(clk), .rst_n(rst_n), .meas(meas), .cfg(cfg),
        .manual_reset(manual_reset),
        .motor_run(motor_run), .sleep_active(sleep_active), .boost_active(boost_active),
        .dry_run_trip(dry_run_trip), .reset_allowed(reset_allowed), .curve_power(curve_power));

    psdm_pump_model psdm_pump_model_i (.clk(clk), .rst_n(rst_n), .motor_run(motor_run), .target(target),
        .meas(meas));

    // free-running 250 MHz clock
    always #2 clk = ~clk;

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles >= LIMIT) begin
            n_fail++;
            tally_and_finish();
        end
    end

    // counts and verdict, then the end of the run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // one comparison, reported at once when it differs
    task automatic check(input string what, input logic [PW-1:0] seen, input logic [PW-1:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // let n edges pass, then stand just after the last one
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    // compare all mode outputs with one expected mode
    task automatic check_mode(input logic run, input logic slp, input logic bst, input logic trp, input logic alw);
        check("motor_run", {19'h0_0000, motor_run}, {19'h0_0000, run});
        check("sleep_active", {19'h0_0000, sleep_active}, {19'h0_0000, slp});
        check("boost_active", {19'h0_0000, boost_active}, {19'h0_0000, bst});
        check("dry_run_trip", {19'h0_0000, dry_run_trip}, {19'h0_0000, trp});
        check("reset_allowed", {19'h0_0000, reset_allowed}, {19'h0_0000, alw});
    endtask : check_mode

    // let n edges pass, then compare all mode outputs
    task automatic mode_after(input int n, input logic run, input logic slp, input logic bst, input logic trp,
                              input logic alw);
        step(n);
        check_mode(run, slp, bst, trp, alw);
    endtask : mode_after

    // one-cycle operator reset pulse
    task automatic pulse_manual();
        manual_reset = 1'b1;
        step(1);
        manual_reset = 1'b0;
    endtask : pulse_manual

    // plain closed-loop settings with a 20..50 Hz, 1000..4000 W curve
    task automatic base_settings();
        cfg = '0;
        cfg.closed_loop = 1'b1;
        cfg.below_curve_sleeps = 1'b1;
        cfg.sleep_s = 16'h0001;
        cfg.dry_s = 8'h1E;
        cfg.interlock_hm = 8'h01;
        cfg.freq_min_pt = 16'h0014;
        cfg.freq_max_pt = 16'h0032;
        cfg.pow_min_pt = 20'h0_03E8;
        cfg.pow_max_pt = 20'h0_0FA0;
        cfg.curve_power_factor = 10'h100;
        cfg.output_freq_upper_limit = 16'h0032;
        cfg.output_freq_lower_limit = 16'h0014;
        cfg.reference_lower_limit = 16'h00C8;
        cfg.wakeup_pressure = 16'h0032;
        target = '{freq: 16'h001E, power: 20'h0_1388, feedback: 16'h012C, reference: 16'h012C};
    endtask : base_settings

    // reset for three cycles, checking the reset state, then release
    task automatic apply_reset();
        rst_n = 1'b0;
        step(3);
        check_mode(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        check("curve_power reset", curve_power, 20'h0_0000);
        rst_n = 1'b1;
        step(3);
    endtask : apply_reset

    initial begin
        clk = 1'b0;
        manual_reset = 1'b0;
        base_settings();
        apply_reset();
        // curve points, 30 and 40 Hz between them, clamping beyond the points and the factor
        for (int i = 0; i < 8; i++) begin
            cfg.curve_power_factor = c_fact[i];
            target.freq = c_freq[i];
            step(3);
            check("curve_power", curve_power, c_exp[i]);
        end
        // a large curve times two saturates
        cfg.pow_min_pt = 20'hF_0000;
        cfg.pow_max_pt = 20'hF_0000;
        cfg.curve_power_factor = 10'h200;
        step(3);
        check("curve_power saturated", curve_power, 20'hF_FFFF);
        // closed loop, low power: sleep after 2 s; a broken condition restarts the count
        base_settings();
        cfg.sleep_s = 16'h0002;
        target.power = 20'h0_01F4;
        mode_after(1500, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        target.power = 20'h0_1388;
        step(10);
        target.power = 20'h0_01F4;
        mode_after(1500, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        mode_after(700, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        // low pressure held for the timer period wakes the pump
        target = '{freq: 16'h001E, power: 20'h0_1388, feedback: 16'h0020, reference: 16'h012C};
        mode_after(1500, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        mode_after(700, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        // pressure over reference at minimum speed also sleeps
        target = '{freq: 16'h0014, power: 20'h0_1388, feedback: 16'h01F4, reference: 16'h012C};
        mode_after(1500, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        mode_after(700, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        // sleep timer zero: sleep ends and low power no longer stops the pump
        cfg.sleep_s = 16'h0000;
        mode_after(3, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        target.power = 20'h0_01F4;
        mode_after(2500, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        // boost before the sleep stop, sleep once the boost pressure is reached
        cfg.sleep_s = 16'h0002;
        cfg.boost_en = 1'b1;
        cfg.boost_setpoint = 16'h0258;
        target.feedback = 16'h012C;
        mode_after(2200, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        target.feedback = 16'h0258;
        mode_after(3, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        // closed-loop dry run with detection off at 30 s: no trip
        cfg.sleep_s = 16'h0000;
        cfg.boost_en = 1'b0;
        cfg.below_curve_sleeps = 1'b0;
        target = '{freq: 16'h0032, power: 20'h0_01F4, feedback: 16'h0064, reference: 16'h012C};
        mode_after(5500, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        // 5 s timeout trips; no reset before the interlock time
        cfg.dry_s = 8'h05;
        mode_after(4000, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        mode_after(1200, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        pulse_manual();
        mode_after(2, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        mode_after(29500, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        mode_after(400, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        pulse_manual();
        target.power = 20'h0_1388;
        mode_after(2, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        // open loop: sleep stays off, low power alone trips, then restart by itself
        cfg.closed_loop = 1'b0;
        cfg.below_curve_sleeps = 1'b1;
        cfg.sleep_s = 16'h0001;
        cfg.auto_reset = 1'b1;
        cfg.restart_s = 16'h0001;
        target = '{freq: 16'h001E, power: 20'h0_01F4, feedback: 16'h012C, reference: 16'h012C};
        mode_after(4000, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        mode_after(1200, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        mode_after(30000, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        mode_after(1000, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        // second reset in mid-run returns to the reset state
        apply_reset();
        check_mode(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        tally_and_finish();
    end
endmodule : test_psdm_monitor
